/* logic/clk_ctl_pkg.sv */
// Constants shared by the clock output and power-down control block.
// Assumes a 32-bit AXI4-Lite master and 8-bit configuration bytes.
package clk_ctl_pkg;

   // Printed configuration byte numbers (register index, byte addr = 4x)
   localparam int unsigned IDX_SPREAD_CFG = 1;
   localparam int unsigned IDX_PAIR_EN = 2;
   localparam int unsigned IDX_REF_CFG = 3;
   localparam int unsigned IDX_DIS_LEVEL = 11;
   localparam int unsigned IDX_STATUS = 16;
   localparam int unsigned BYTE_PER_REG = 4;
   localparam logic [7:0] ADDR_SPREAD_CFG = 8'(IDX_SPREAD_CFG * BYTE_PER_REG);
   localparam logic [7:0] ADDR_PAIR_EN = 8'(IDX_PAIR_EN * BYTE_PER_REG);
   localparam logic [7:0] ADDR_REF_CFG = 8'(IDX_REF_CFG * BYTE_PER_REG);
   localparam logic [7:0] ADDR_DIS_LEVEL = 8'(IDX_DIS_LEVEL * BYTE_PER_REG);
   localparam logic [7:0] ADDR_STATUS = 8'(IDX_STATUS * BYTE_PER_REG);

   // Field positions
   localparam int unsigned SPREAD_LSB = 3;
   localparam int unsigned REF_EN_BIT = 4;
   localparam int unsigned REF_PD_RUN_BIT = 5;
   localparam int unsigned STAT_ADDR_LSB = 8;
   localparam int unsigned STAT_SPREAD_LSB = 16;
   localparam int unsigned STAT_STATE_LSB = 20;
   localparam int unsigned STAT_STRAP_BIT = 24;

   // Reset values
   localparam logic [7:0] RST_SPREAD_CFG = 8'h00;
   localparam logic [7:0] RST_PAIR_EN = 8'h3F;
   localparam logic [7:0] RST_REF_CFG = 8'h10;
   localparam logic [7:0] RST_DIS_LEVEL = 8'h00;

   // Bus address choices from the address strap
   localparam logic [6:0] BUS_ADDR_STRAP0 = 7'b1101000;
   localparam logic [6:0] BUS_ADDR_STRAP1 = 7'b1101010;

   // Spread codes: software code 01 asks for the smaller spread
   localparam logic [1:0] SPREAD_OFF = 2'h0;
   localparam logic [1:0] SPREAD_QUARTER = 2'h1;
   localparam logic [1:0] SPREAD_HALF = 2'h2;
   localparam logic [1:0] SPREAD_SW_QUARTER = 2'h1;

   // Tri-level strap encoding after the pad comparators
   localparam logic [1:0] TRI_HIGH = 2'h2;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Power sequencing states
   typedef enum logic [1:0] {
      ST_FIRST_WAIT = 2'b00,
      ST_RUN = 2'b01,
      ST_POWER_DOWN = 2'b10
   } pwr_state_e;

endpackage

/* logic/clk_out_ctl.sv */
// Output enable, power-down sequencing and strap capture of a
// six-pair clock generator, with AXI4-Lite configuration registers.
// Assumes link_clk stands in for the synthesiser clock and runs free;
// pins arrive asynchronously and are synchronised here.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module clk_out_ctl
   import clk_ctl_pkg::*;
#(
   parameter int unsigned NUM_PAIRS = 6
) (
   // Register clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // Output synthesiser clock
   input wire logic link_clk,
   // AXI4-Lite write address and data
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // AXI4-Lite write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // AXI4-Lite read
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // Board pins
   input wire logic power_down_pin_n,
   input wire logic [NUM_PAIRS-1:0] pair_enable_pin_n,
   input wire logic [1:0] spread_strap,
   // Shared strap / reference clock pin
   input wire logic address_strap,
   output logic reference_clock_out,
   output logic reference_clock_oe,
   // Differential outputs
   output logic [NUM_PAIRS-1:0] diff_clock_true,
   output logic [NUM_PAIRS-1:0] diff_clock_complement,
   // Captured configuration
   output logic [6:0] bus_address,
   output logic [1:0] spread_mode
);

   localparam int unsigned PIN_W = NUM_PAIRS + 4;
   localparam int unsigned XW = NUM_PAIRS + 3;

   // Pin synchronisers (ref_clk)
   logic [PIN_W-1:0] pins_sync; // Pins after two flops
   logic pd_high; // Power-down pin is high (running)
   logic [NUM_PAIRS-1:0] oe_pin_n; // Synchronised enable pins
   logic addr_strap_s; // Synchronised address strap
   logic [1:0] spread_strap_s; // Synchronised tri-level strap

   sync_bank #(.WIDTH(PIN_W), .RST_VAL('0)) u_pin_sync (
      .clk(ref_clk),
      .rst(srst),
      .async_in({power_down_pin_n, pair_enable_pin_n, address_strap,
                 spread_strap}),
      .sync_out(pins_sync)
   );

   assign pd_high = pins_sync[PIN_W-1];
   assign oe_pin_n = pins_sync[PIN_W-2:3];
   assign addr_strap_s = pins_sync[2];
   assign spread_strap_s = pins_sync[1:0];

   // Power sequencing
   pwr_state_e state_ff; // Power state
   pwr_state_e nxt_state;
   logic addr_sel_ff; // Latched address strap
   logic nxt_addr_sel;
   logic spread_half_ff; // Latched spread strap is high
   logic nxt_spread_half;

   // Next state and strap capture
   always_comb begin
      nxt_state = state_ff;
      nxt_addr_sel = addr_sel_ff;
      nxt_spread_half = spread_half_ff;
      unique case (state_ff)
         ST_FIRST_WAIT: begin
            // Only the first high captures the straps
            if (pd_high) begin
               nxt_addr_sel = addr_strap_s;
               nxt_spread_half = (spread_strap_s == TRI_HIGH);
               nxt_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!pd_high) begin
               nxt_state = ST_POWER_DOWN;
            end
         end
         ST_POWER_DOWN: begin
            // Resume without touching the captured straps
            if (pd_high) begin
               nxt_state = ST_RUN;
            end
         end
         default: begin
            nxt_state = ST_FIRST_WAIT;
         end
      endcase
      if (srst) begin
         nxt_state = ST_FIRST_WAIT;
         nxt_addr_sel = 1'b0;
         nxt_spread_half = 1'b0;
      end
   end

   // Register power state and straps
   always_ff @(posedge ref_clk) begin
      state_ff <= nxt_state;
      addr_sel_ff <= nxt_addr_sel;
      spread_half_ff <= nxt_spread_half;
   end

   // Configuration registers
   logic [7:0] spread_cfg_ff; // Byte 1
   logic [7:0] pair_en_ff; // Per-pair enable bits
   logic [7:0] ref_cfg_ff; // Byte 3
   logic [7:0] dis_level_ff; // Byte 11
   logic [7:0] nxt_spread_cfg;
   logic [7:0] nxt_pair_en;
   logic [7:0] nxt_ref_cfg;
   logic [7:0] nxt_dis_level;

   // Write channel holding
   logic aw_held_ff; // Address accepted, waiting for data
   logic w_held_ff; // Data accepted, waiting for address
   logic [7:0] aw_addr_ff; // Held write address
   logic [7:0] w_data_ff; // Held write byte
   logic w_lane_ff; // Held low-lane strobe
   logic bvalid_ff; // Write response pending
   logic [1:0] bresp_ff; // Write response code
   logic nxt_aw_held;
   logic nxt_w_held;
   logic [7:0] nxt_aw_addr;
   logic [7:0] nxt_w_data;
   logic nxt_w_lane;
   logic nxt_bvalid;
   logic [1:0] nxt_bresp;
   logic do_write; // Address and data both present

   // Read channel
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic nxt_rvalid;
   logic [31:0] nxt_rdata;
   logic [1:0] nxt_rresp;

   // True for offsets that hold a register
   function automatic logic addr_mapped(input logic [7:0] a);
      return (a == ADDR_SPREAD_CFG) || (a == ADDR_PAIR_EN) ||
             (a == ADDR_REF_CFG) || (a == ADDR_DIS_LEVEL) ||
             (a == ADDR_STATUS);
   endfunction

   // Word-aligned byte offset of a bus address
   function automatic logic [7:0] word_addr(input logic [7:0] a);
      return {a[7:2], 2'b00};
   endfunction

   // Write halves ready while not already held and no answer pending; read ready while no read answer pending
   assign s_axi_awready = !aw_held_ff && !bvalid_ff;
   assign s_axi_wready = !w_held_ff && !bvalid_ff;
   assign s_axi_arready = !rvalid_ff;

   // Write path: either order, response once both arrive
   always_comb begin
      nxt_aw_held = aw_held_ff;
      nxt_w_held = w_held_ff;
      nxt_aw_addr = aw_addr_ff;
      nxt_w_data = w_data_ff;
      nxt_w_lane = w_lane_ff;
      nxt_bvalid = bvalid_ff;
      nxt_bresp = bresp_ff;
      nxt_spread_cfg = spread_cfg_ff;
      nxt_pair_en = pair_en_ff;
      nxt_ref_cfg = ref_cfg_ff;
      nxt_dis_level = dis_level_ff;
      if (s_axi_awvalid && s_axi_awready) begin
         nxt_aw_held = 1'b1;
         nxt_aw_addr = word_addr(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready) begin
         nxt_w_held = 1'b1;
         nxt_w_data = s_axi_wdata[7:0];
         nxt_w_lane = s_axi_wstrb[0];
      end
      if (s_axi_bvalid && s_axi_bready) begin
         nxt_bvalid = 1'b0;
      end
      if (do_write) begin
         nxt_aw_held = 1'b0;
         nxt_w_held = 1'b0;
         nxt_bvalid = 1'b1;
         nxt_bresp = addr_mapped(aw_addr_ff) ? RESP_OKAY : RESP_SLVERR;
         // Only the low lane carries data; status is read-only
         if (w_lane_ff) begin
            if (aw_addr_ff == ADDR_SPREAD_CFG) begin
               nxt_spread_cfg = w_data_ff;
            end
            if (aw_addr_ff == ADDR_PAIR_EN) begin
               nxt_pair_en = w_data_ff;
            end
            if (aw_addr_ff == ADDR_REF_CFG) begin
               nxt_ref_cfg = w_data_ff;
            end
            if (aw_addr_ff == ADDR_DIS_LEVEL) begin
               nxt_dis_level = w_data_ff;
            end
         end
      end
      if (srst) begin
         nxt_aw_held = 1'b0;
         nxt_w_held = 1'b0;
         nxt_bvalid = 1'b0;
         nxt_bresp = RESP_OKAY;
         nxt_spread_cfg = RST_SPREAD_CFG;
         nxt_pair_en = RST_PAIR_EN;
         nxt_ref_cfg = RST_REF_CFG;
         nxt_dis_level = RST_DIS_LEVEL;
      end
   end

   assign do_write = aw_held_ff && w_held_ff;

   // Register write path
   always_ff @(posedge ref_clk) begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff <= nxt_w_held;
      aw_addr_ff <= nxt_aw_addr;
      w_data_ff <= nxt_w_data;
      w_lane_ff <= nxt_w_lane;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      spread_cfg_ff <= nxt_spread_cfg;
      pair_en_ff <= nxt_pair_en;
      ref_cfg_ff <= nxt_ref_cfg;
      dis_level_ff <= nxt_dis_level;
   end

   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;

   // Output decisions
   logic [NUM_PAIRS-1:0] pair_run; // Pairs that toggle
   logic ref_run; // Reference toggles
   logic ref_drive; // Reference pin driven
   logic [1:0] spread_eff; // Effective spread
   logic [31:0] status_word; // Read-back of live state

   // Decide which outputs run
   always_comb begin
      pair_run = '0;
      if (state_ff == ST_RUN) begin
         // Pin and bit must both allow the pair
         pair_run = pair_en_ff[NUM_PAIRS-1:0] & ~oe_pin_n;
      end
      // Reference is floated until the straps are taken
      ref_drive = (state_ff != ST_FIRST_WAIT);
      ref_run = ref_cfg_ff[REF_EN_BIT];
      if (state_ff == ST_POWER_DOWN) begin
         ref_run = ref_cfg_ff[REF_PD_RUN_BIT];
      end
      if (state_ff == ST_FIRST_WAIT) begin
         ref_run = 1'b0;
      end
      // Software quarter spread overrides the strap
      if (spread_cfg_ff[SPREAD_LSB +: 2] == SPREAD_SW_QUARTER) begin
         spread_eff = SPREAD_QUARTER;
      end else if (spread_half_ff) begin
         spread_eff = SPREAD_HALF;
      end else begin
         spread_eff = SPREAD_OFF;
      end
   end

   assign status_word = {7'h00, (state_ff != ST_FIRST_WAIT),
                         2'h0, state_ff, 2'h0, spread_eff,
                         1'b0, bus_address, 2'h0, pair_run};

   // Read path: one cycle from address to data
   always_comb begin
      nxt_rvalid = rvalid_ff;
      nxt_rdata = rdata_ff;
      nxt_rresp = rresp_ff;
      if (s_axi_rvalid && s_axi_rready) begin
         nxt_rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         nxt_rvalid = 1'b1;
         nxt_rresp = RESP_OKAY;
         unique case (word_addr(s_axi_araddr))
            ADDR_SPREAD_CFG: nxt_rdata = {24'h00_0000, spread_cfg_ff};
            ADDR_PAIR_EN: nxt_rdata = {24'h00_0000, pair_en_ff};
            ADDR_REF_CFG: nxt_rdata = {24'h00_0000, ref_cfg_ff};
            ADDR_DIS_LEVEL: nxt_rdata = {24'h00_0000, dis_level_ff};
            ADDR_STATUS: nxt_rdata = status_word;
            default: begin
               // Unmapped offsets read zero with an error
               nxt_rdata = 32'h0000_0000;
               nxt_rresp = RESP_SLVERR;
            end
         endcase
      end
      if (srst) begin
         nxt_rvalid = 1'b0;
         nxt_rdata = 32'h0000_0000;
         nxt_rresp = RESP_OKAY;
      end
   end

   // Register read path
   always_ff @(posedge ref_clk) begin
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
   end

   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;

   // Captured address, fixed until the next full reset
   assign bus_address = addr_sel_ff ? BUS_ADDR_STRAP1
                                    : BUS_ADDR_STRAP0;
   assign spread_mode = spread_eff;

   // Crossing into the link clock
   // Quasi-static levels, so a plain two-flop bank is enough
   logic [XW-1:0] link_ctl; // Run bits and disabled level, synced
   logic [XW+1:0] link_in; // Includes reset and reference drive
   logic [XW+1:0] link_sync;
   logic link_rst; // Reset as seen by link logic
   logic link_ref_drive;
   logic [NUM_PAIRS-1:0] link_pair_run;
   logic link_ref_run;
   logic [1:0] link_dis; // Disabled level for true/complement

   assign link_in = {srst, ref_drive, ref_run, pair_run,
                     dis_level_ff[1:0]};

   sync_bank #(.WIDTH(XW + 2), .RST_VAL('0)) u_link_sync (
      .clk(link_clk),
      .rst(1'b0),
      .async_in(link_in),
      .sync_out(link_sync)
   );

   assign link_rst = link_sync[XW+1];
   assign link_ref_drive = link_sync[XW];
   assign link_ctl = link_sync[XW-1:0];
   assign link_ref_run = link_ctl[XW-1];
   assign link_pair_run = link_ctl[XW-2:2];
   assign link_dis = link_ctl[1:0];

   // Output drivers (link_clk)
   logic phase_ff; // Free toggle for running outputs
   logic [NUM_PAIRS-1:0] true_ff;
   logic [NUM_PAIRS-1:0] comp_ff;
   logic ref_out_ff;
   logic ref_oe_ff;
   logic nxt_phase;
   logic [NUM_PAIRS-1:0] nxt_true;
   logic [NUM_PAIRS-1:0] nxt_comp;
   logic nxt_ref_out;
   logic nxt_ref_oe;

   // Running pairs toggle; stopped ones hold the chosen level
   always_comb begin
      nxt_phase = ~phase_ff;
      for (int i = 0; i < NUM_PAIRS; i++) begin
         // Power down and disabled both use byte 11 level
         nxt_true[i] = link_pair_run[i] ? phase_ff : link_dis[0];
         nxt_comp[i] = link_pair_run[i] ? ~phase_ff : link_dis[1];
      end
      nxt_ref_out = link_ref_run ? phase_ff : 1'b0;
      nxt_ref_oe = link_ref_drive;
      if (link_rst) begin
         nxt_phase = 1'b0;
         nxt_true = '0;
         nxt_comp = '0;
         nxt_ref_out = 1'b0;
         nxt_ref_oe = 1'b0;
      end
   end

   // Register the pins
   always_ff @(posedge link_clk) begin
      phase_ff <= nxt_phase;
      true_ff <= nxt_true;
      comp_ff <= nxt_comp;
      ref_out_ff <= nxt_ref_out;
      ref_oe_ff <= nxt_ref_oe;
   end

   assign diff_clock_true = true_ff;
   assign diff_clock_complement = comp_ff;
   assign reference_clock_out = ref_out_ff;
   assign reference_clock_oe = ref_oe_ff;

endmodule // clk_out_ctl
`default_nettype wire

/* logic/sync_bank.sv */
// Two-flop synchroniser bank for quasi-static levels.
// Assumes each bit changes rarely relative to the destination clock.
`timescale 1ns/1ps
`default_nettype none
module sync_bank #(
   parameter int unsigned WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // Destination clock and reset
   input wire logic clk,
   input wire logic rst,
   // Level from another domain or a pin
   input wire logic [WIDTH-1:0] async_in,
   // Level safe to use in the clk domain
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_ff; // First stage, read only by stage two
   logic [WIDTH-1:0] sync_ff; // Second stage
   logic [WIDTH-1:0] nxt_meta;
   logic [WIDTH-1:0] nxt_sync;

   // Next values; reset forces the constant
   always_comb begin
      nxt_meta = rst ? RST_VAL : async_in;
      nxt_sync = rst ? RST_VAL : meta_ff;
   end

   // Register both stages
   always_ff @(posedge clk) begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
   end

   assign sync_out = sync_ff;

endmodule // sync_bank
`default_nettype wire

/* sim/board_model.sv */
// Board side: straps, enable jumpers and the shared strap/reference pin.
// Assumes the bench sets wanted levels; the pins follow them at once.
`timescale 1ns/1ps
`default_nettype none
module board_model (
   // Wanted board settings
   input wire logic pd_req_n,
   input wire logic [5:0] en_req_n,
   input wire logic addr_lvl,
   input wire logic [1:0] spread_lvl,
   // Driver side of the shared pin
   input wire logic reference_clock_out,
   input wire logic reference_clock_oe,
   // Pins into the block
   output logic power_down_pin_n,
   output logic [5:0] pair_enable_pin_n,
   output logic [1:0] spread_strap,
   output logic address_strap
);
   // Pin levels; a driven shared pin hides the strap resistor
   always_comb begin
      power_down_pin_n = pd_req_n;
      pair_enable_pin_n = en_req_n;
      spread_strap = spread_lvl;
      address_strap = reference_clock_oe ? reference_clock_out : addr_lvl;
   end
endmodule // board_model
`default_nettype wire

/* sim/clk_out_ctl_assertions.sv */
// Port checks for the clock output and power-down control block.
// Bound into clk_out_ctl; pair checks on link_clk.
`timescale 1ns/1ps
`default_nettype none
module clk_out_ctl_assertions
   import clk_ctl_pkg::*;
#(
   parameter int unsigned NUM_PAIRS = 6
) (
   // Clocks and reset
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic link_clk,
   // Bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // Pins and outputs
   input wire logic power_down_pin_n,
   input wire logic [NUM_PAIRS-1:0] pair_enable_pin_n,
   input wire logic reference_clock_oe,
   input wire logic [NUM_PAIRS-1:0] diff_clock_true,
   input wire logic [NUM_PAIRS-1:0] diff_clock_complement,
   input wire logic [6:0] bus_address
);
   // Read data one edge after address taken
   a_read_answer: assert property (@(posedge ref_clk) disable iff (srst)
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   // Write answer two edges after both halves taken
   a_write_answer: assert property (@(posedge ref_clk) disable iff (srst)
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   // Read answer stands until taken
   a_read_hold: assert property (@(posedge ref_clk) disable iff (srst)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   // Write answer stands, with a legal code
   a_write_hold: assert property (@(posedge ref_clk) disable iff (srst)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)
      && (s_axi_bresp == RESP_OKAY || s_axi_bresp == RESP_SLVERR))
      else $error("write answer dropped");
   // No new write taken while an answer is pending
   a_write_refuse: assert property (@(posedge ref_clk) disable iff (srst)
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while busy");
   // Address fixed while powered down
   a_addr_held: assert property (
      @(posedge ref_clk) disable iff (srst)
      !power_down_pin_n [*4] |=> $stable(bus_address))
      else $error("bus address moved in power down");
   // Pairs still once power down settles
   a_pd_quiet: assert property (
      @(posedge link_clk) disable iff (srst)
      !power_down_pin_n [*8] |-> $stable(diff_clock_true)
      && $stable(diff_clock_complement))
      else $error("pair moved in power down");
   // Pin-disabled pair stops toggling
   a_pin_disable: assert property (
      @(posedge link_clk) disable iff (srst)
      pair_enable_pin_n[0] [*8] |-> !($changed(diff_clock_true[0])
      && $changed(diff_clock_complement[0])))
      else $error("pair runs with its pin high");
   // Reference floats again only through reset
   a_ref_oe_kept: assert property (
      @(posedge link_clk) disable iff (srst) !$fell(reference_clock_oe))
      else $error("reference released without reset");
   // Main scenarios reached
   c_write: cover property (@(posedge ref_clk) s_axi_bvalid && s_axi_bready);
   c_read: cover property (@(posedge ref_clk) s_axi_rvalid && s_axi_rready);
   c_ref_on: cover property (@(posedge link_clk) $rose(reference_clock_oe));
endmodule // clk_out_ctl_assertions
bind clk_out_ctl clk_out_ctl_assertions #(.NUM_PAIRS(NUM_PAIRS)) u_chk (.*);
`default_nettype wire

/* sim/clk_out_ctl_test.sv */
// Bench for the clock control block: bus tasks, pin settings, output watch.
// Assumes board_model at the pins and the checker bound into the block.
`timescale 1ns/1ps
`default_nettype none
module clk_out_ctl_test
   import clk_ctl_pkg::*;
;
   localparam logic [7:0] RA [4] = '{ADDR_SPREAD_CFG, ADDR_PAIR_EN,
      ADDR_REF_CFG, ADDR_DIS_LEVEL};
   localparam logic [7:0] RS [4] = '{RST_SPREAD_CFG, RST_PAIR_EN,
      RST_REF_CFG, RST_DIS_LEVEL};
   logic ref_clk, link_clk, srst, awv, awr, wv, wr_, bv, br, arv, arr, rv, rr;
   logic [7:0] awa, ara;
   logic [31:0] wd, rd_;
   logic [3:0] ws;
   logic [1:0] bresp, rresp, s_lvl, s_pin, smode;
   logic pd_n, a_lvl, pd_pin, a_pin, oe, r_out;
   logic [5:0] en_n, en_pin, dt, dc;
   logic [6:0] baddr;
   int failures, n_compared;

   // Register clock and unrelated link clock
   initial begin ref_clk = 0; forever #10 ref_clk = ~ref_clk; end
   initial begin link_clk = 0; #7; forever #15 link_clk = ~link_clk; end

   clk_out_ctl uut (.ref_clk(ref_clk), .srst(srst),
      .link_clk(link_clk), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr_),
      .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_bvalid(bv),
      .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
      .s_axi_rready(rr), .s_axi_rdata(rd_), .s_axi_rresp(rresp),
      .power_down_pin_n(pd_pin), .pair_enable_pin_n(en_pin),
      .spread_strap(s_pin), .address_strap(a_pin),
      .reference_clock_out(r_out), .reference_clock_oe(oe),
      .diff_clock_true(dt), .diff_clock_complement(dc),
      .bus_address(baddr), .spread_mode(smode));
   board_model board (.pd_req_n(pd_n), .en_req_n(en_n), .addr_lvl(a_lvl),
      .spread_lvl(s_lvl), .reference_clock_out(r_out),
      .reference_clock_oe(oe), .power_down_pin_n(pd_pin),
      .pair_enable_pin_n(en_pin), .spread_strap(s_pin),
      .address_strap(a_pin));

   // Verdict and end of run
   task automatic results;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("Error at %0t: got %h exp %h", $time, g, e);
      end
   endtask

   // One clock edge of a bounded wait
   task automatic tick(inout int n);
      @(negedge ref_clk);
      n++;
      if (n > 200) begin
         failures++;
         $display("Error at %0t: wait got %h exp %h", $time, 0, 1);
         results;
      end
   endtask

   // Bus write; answer taken late so the slave must hold it
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
         input logic [1:0] er);
      int n;
      logic ad, dd, hit;
      logic [1:0] gr;
      n = 0; ad = 0; dd = 0;
      @(posedge ref_clk);
      awv <= 1; awa <= a; wv <= 1; wd <= {24'h0, d};
      do begin
         tick(n);
         ad = ad || (awv && awr);
         dd = dd || (wv && wr_);
         hit = bv && br;
         gr = bresp;
         @(posedge ref_clk);
         awv <= !ad;
         wv <= !dd;
         br <= ad && dd && n > 2 && !hit;
      end while (!hit);
      chk(32'(gr), 32'(er));
   endtask

   // Bus read compared under a mask
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
         input logic [31:0] m, input logic [1:0] er);
      int n;
      logic t, hit;
      logic [31:0] gd;
      logic [1:0] gr;
      n = 0;
      @(posedge ref_clk);
      arv <= 1; ara <= a;
      do begin
         tick(n);
         t = arv && arr;
         hit = rv && rr;
         gd = rd_;
         gr = rresp;
         @(posedge ref_clk);
         arv <= arv && !t;
         rr <= n > 2 && !hit;
      end while (!hit);
      chk(gd & m, e & m);
      chk(32'(gr), 32'(er));
   endtask

   // Margin for pin synchronisers and the link crossing
   task automatic settle;
      repeat (20) @(posedge ref_clk);
   endtask

   task automatic pins(input logic p, input logic [5:0] e, input logic a,
         input logic [1:0] s);
      @(posedge ref_clk);
      pd_n <= p; en_n <= e; a_lvl <= a; s_lvl <= s;
      settle;
   endtask

   // Watch outputs: toggles, parked levels, {oe, ref running}
   task automatic outs(input logic [5:0] run, input logic [1:0] lvl,
         input logic [1:0] rx);
      logic [5:0] t0, tg;
      logic r0, rt;
      tg = 0;
      rt = 0;
      @(posedge link_clk) #1;
      t0 = dt;
      r0 = r_out;
      repeat (8) begin
         @(posedge link_clk) #1;
         tg = tg | (t0 ^ dt);
         rt = rt | (r0 ^ r_out);
         t0 = dt;
         r0 = r_out;
      end
      chk(32'(tg), 32'(run));
      for (int i = 0; i < 6; i++)
         if (!run[i]) chk(32'({dc[i], dt[i]}), 32'(lvl));
      chk(32'({oe, rt}), 32'(rx));
      if (rx == 2'h2) chk(32'(r_out), 32'h0);
   endtask

   // Status read: pairs, address, spread and state expected
   task automatic rs(input logic [5:0] r, input logic [6:0] a,
         input logic [1:0] s, input logic [1:0] p);
      rd(ADDR_STATUS, {7'h0, 1'b1, 2'h0, p, 2'h0, s, 1'b0, a, 2'h0, r}, '1,
         RESP_OKAY);
   endtask

   initial begin
      srst = 1; awv = 0; wv = 0; br = 0; arv = 0; rr = 0; ws = 4'hF;
      pd_n = 0; en_n = 6'h00; a_lvl = 1; s_lvl = 2'h2;
      repeat (6) @(posedge ref_clk);
      srst <= 0;
      settle;
      rd(ADDR_STATUS, 32'h0, 32'h0130_003F, RESP_OKAY);
      outs(6'h00, 2'h0, 2'h0);
      for (int i = 0; i < 4; i++) rd(RA[i], 32'(RS[i]), '1, RESP_OKAY);
      rd(8'h20, 32'h0, '1, RESP_SLVERR);
      wr(8'h20, 8'h55, RESP_SLVERR);
      pins(1, 6'h00, 1, 2'h2);
      rs(6'h3F, BUS_ADDR_STRAP1, SPREAD_HALF, ST_RUN);
      chk(32'(baddr), 32'(BUS_ADDR_STRAP1));
      chk(32'(smode), 32'(SPREAD_HALF));
      outs(6'h3F, 2'h0, 2'h3);
      pins(1, 6'h05, 1, 2'h2);
      outs(6'h3A, 2'h0, 2'h3);
      wr(ADDR_PAIR_EN, 8'h3C, RESP_OKAY);
      settle;
      outs(6'h38, 2'h0, 2'h3);
      // Levels in gray order so one leg moves per step
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_DIS_LEVEL, 8'(i ^ (i >> 1)), RESP_OKAY);
         settle;
         outs(6'h38, 2'(i ^ (i >> 1)), 2'h3);
      end
      @(posedge ref_clk);
      ws <= 4'h0;
      wr(ADDR_DIS_LEVEL, 8'h01, RESP_OKAY);
      ws <= 4'hF;
      rd(ADDR_DIS_LEVEL, 32'h2, '1, RESP_OKAY);
      wr(ADDR_REF_CFG, 8'h00, RESP_OKAY);
      settle;
      outs(6'h38, 2'h2, 2'h2);
      pins(0, 6'h00, 0, 2'h0);
      outs(6'h00, 2'h2, 2'h2);
      rs(6'h00, BUS_ADDR_STRAP1, SPREAD_HALF, ST_POWER_DOWN);
      wr(ADDR_REF_CFG, 8'h30, RESP_OKAY);
      settle;
      outs(6'h00, 2'h2, 2'h3);
      pins(1, 6'h00, 0, 2'h0);
      rs(6'h3C, BUS_ADDR_STRAP1, SPREAD_HALF, ST_RUN);
      outs(6'h3C, 2'h2, 2'h3);
      wr(ADDR_SPREAD_CFG, 8'h08, RESP_OKAY);
      chk(32'(smode), 32'(SPREAD_SW_QUARTER));
      // Power cycle with other straps
      @(posedge ref_clk);
      srst <= 1; pd_n <= 0; s_lvl <= 2'h1;
      repeat (8) @(posedge ref_clk);
      srst <= 0;
      pins(1, 6'h00, 0, 2'h1);
      rs(6'h3F, BUS_ADDR_STRAP0, SPREAD_OFF, ST_RUN);
      results;
   end
endmodule // clk_out_ctl_test
`default_nettype wire
